// ===== rtl/hw_watchdog_reset_unit.v
// What this block does
// - overflow holds processor reset for half a tick plus the restart count
// - processor restarts after 4100 crystal ticks
// - overflow sets watchdog_overflow_flag, readable
// - overflow flag kept in battery-backed storage
// - external reset pin clears overflow flag
// - crystal stop sets flag, resets on resume
// - nothing internal can disable the watchdog
// - writing refresh bit restarts the count
// - sleep-exit low or emulator 0x14 restarts
// - hardware reset from five listed sources
// - pin or power fault halts digital logic
// - pin or power fault clears configuration
// - sense tied to supply disables watchdog
//
// Purpose: watchdog, crystal monitor and reset combiner with AXI4-Lite registers
// Assumes: crystal_tick, pins and comparator levels are asynchronous; rstn is power-on only
// Notes: overflow flag lives in the battery domain, reset only by rstn, the reset pin and the firmware clear bit
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`include "wdt_consts.vh"
module hw_watchdog_reset_unit #(
  parameter WDT_LIMIT = `WDT_LIMIT_TICKS,
  parameter RESTART_TICKS = `RESTART_TICKS,
  parameter SLOW_TIMEOUT = `SLOW_TIMEOUT_CYC
) (
  input wire mclk, // 10 MHz clock
  input wire rstn, // async reset, active low
  input wire ce, // clock enable
  input wire crystal_tick, // 32.768 kHz crystal level
  input wire external_reset_pin_n, // external reset pin, active low
  input wire emu_reset_n, // emulator reset pin, active low
  input wire power_fault_below_bias, // sense below bias_reference_level
  input wire power_fault_at_supply, // sense strapped to main_supply_rail
  input wire sleep_exit, // sleep-exit level, low restarts the count
  input wire emu_cmd_valid, // debug_emulator_port command strobe, same clock
  input wire [7:0] emu_cmd, // debug_emulator_port command code
  output reg cpu_reset, // processor reset, active high
  output reg sys_reset, // system reset, halts digital logic
  output reg config_clear, // clears configuration RAM
  output reg cpu_start, // one-cycle pulse: run from address zero
  output wire irq, // interrupt level
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready // read data ready
);
  localparam ST_RUN = 3'b001;
  localparam ST_HOLD = 3'b010;
  localparam ST_WAIT = 3'b100;

  // pins pass two flops; the reset pin idles high
  wire [4:0] s_in;
  sync2 #(.W(5), .INIT(5'h18)) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .ce(ce),
    .d({emu_reset_n, external_reset_pin_n, power_fault_below_bias, power_fault_at_supply, crystal_tick}),
    .q(s_in)
  );
  wire s_tick = s_in[0];
  wire s_strap = s_in[1];
  wire s_pfail = s_in[2] & ~s_in[1];
  wire s_xrst_n = s_in[3];
  wire s_erst_n = s_in[4];

  function addr_hit;
    input [7:0] a;
    input [7:0] r;
    begin
      addr_hit = (a[7:2] == r[7:2]);
    end
  endfunction

  reg tick_d;
  wire tick_rise = s_tick & ~tick_d;
  wire halt = ~s_xrst_n | s_pfail;

  // crystal monitor: no tick edge within SLOW_TIMEOUT mclk cycles means stopped or slow
  reg [15:0] gap_cnt;
  reg xtal_bad;
  wire xtal_resume = xtal_bad & tick_rise;

  reg [15:0] wdt_cnt;
  reg [12:0] restart_cnt;
  reg [2:0] state;
  reg watchdog_overflow_flag;
  reg [`IRQ_WIDTH-1:0] irq_stat;
  reg [`IRQ_WIDTH-1:0] irq_mask;

  wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid & ce;
  wire rd_go = s_axi_arvalid & ~s_axi_rvalid & ce;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;

  wire wr_ctrl = wr_go & addr_hit(s_axi_awaddr, `REG_CTRL) & s_axi_wstrb[0];
  wire wr_istat = wr_go & addr_hit(s_axi_awaddr, `REG_IRQ_STAT) & s_axi_wstrb[0];
  wire wr_imask = wr_go & addr_hit(s_axi_awaddr, `REG_IRQ_MASK) & s_axi_wstrb[0];
  wire refresh_wr = wr_ctrl & s_axi_wdata[`CTRL_REFRESH_BIT];
  wire clr_ovf_wr = wr_ctrl & s_axi_wdata[`CTRL_CLR_OVF_BIT];
  wire emu_refresh = emu_cmd_valid & (emu_cmd == `EMU_REFRESH_CMD);
  wire wdt_enable = ~s_strap;
  wire refresh = refresh_wr | emu_refresh | ~sleep_exit;
  wire wdt_ovf = wdt_enable & (state == ST_RUN) & tick_rise
    & (wdt_cnt == WDT_LIMIT[15:0] - 16'h0001);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tick_d <= 1'b0;
      gap_cnt <= 16'h0000;
      xtal_bad <= 1'b0;
    end else if (ce) begin
      tick_d <= s_tick;
      if (tick_rise) begin
        gap_cnt <= 16'h0000;
        xtal_bad <= 1'b0;
      end else if (gap_cnt >= SLOW_TIMEOUT[15:0] - 16'h0001) begin
        xtal_bad <= wdt_enable;
      end else begin
        gap_cnt <= gap_cnt + 16'h0001;
      end
    end
  end

  // watchdog counter on crystal ticks; no register can stop it
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wdt_cnt <= 16'h0000;
    end else if (ce) begin
      if (refresh | ~wdt_enable | wdt_ovf | halt | (state != ST_RUN)) begin
        wdt_cnt <= 16'h0000;
      end else if (tick_rise) begin
        wdt_cnt <= wdt_cnt + 16'h0001;
      end
    end
  end

  // restart sequencer: overflow holds the processor half a tick, then counts 4100 ticks
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_RUN;
      restart_cnt <= 13'h0000;
      cpu_start <= 1'b0;
    end else if (ce) begin
      cpu_start <= 1'b0;
      case (state)
        ST_RUN: begin
          if (wdt_ovf | xtal_resume) begin
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (~s_tick) begin
            state <= ST_WAIT;
            restart_cnt <= 13'h0000;
          end
        end
        ST_WAIT: begin
          if (tick_rise) begin
            if (restart_cnt == RESTART_TICKS[12:0] - 13'h0001) begin
              state <= ST_RUN;
              cpu_start <= 1'b1;
            end else begin
              restart_cnt <= restart_cnt + 13'h0001;
            end
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // battery-backed flag: only power-on reset and the reset pin clear it besides firmware
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      watchdog_overflow_flag <= 1'b0;
    end else if (ce) begin
      if (wdt_ovf | (xtal_bad & ~halt)) begin
        watchdog_overflow_flag <= 1'b1;
      end else if (~s_xrst_n) begin
        watchdog_overflow_flag <= 1'b0;
      end else if (clr_ovf_wr) begin
        watchdog_overflow_flag <= 1'b0;
      end
    end
  end

  // reset outputs
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_reset <= 1'b1;
      sys_reset <= 1'b1;
      config_clear <= 1'b1;
    end else if (ce) begin
      sys_reset <= halt | ~s_erst_n | xtal_bad;
      cpu_reset <= halt | ~s_erst_n | xtal_bad | (state != ST_RUN);
      config_clear <= halt;
    end
  end

  // interrupt status, set wins over write-one-to-clear
  wire [`IRQ_WIDTH-1:0] irq_set;
  assign irq_set[`IRQ_OVF_BIT] = wdt_ovf;
  // one-cycle event in the cycle the monitor first declares the crystal bad
  assign irq_set[`IRQ_XTAL_BIT] = wdt_enable & ~xtal_bad & ~tick_rise
    & (gap_cnt >= SLOW_TIMEOUT[15:0] - 16'h0001);
  genvar gi;
  generate
    for (gi = 0; gi < `IRQ_WIDTH; gi = gi + 1) begin : g_irq
      always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
          irq_stat[gi] <= 1'b0;
        end else if (ce) begin
          if (irq_set[gi]) begin
            irq_stat[gi] <= 1'b1;
          end else if (wr_istat & s_axi_wdata[gi]) begin
            irq_stat[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  assign irq = |(irq_stat & irq_mask);

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      irq_mask <= {`IRQ_WIDTH{1'b0}};
    end else if (ce & wr_imask) begin
      irq_mask <= s_axi_wdata[`IRQ_WIDTH-1:0];
    end
  end

  // write response
  wire wr_known = addr_hit(s_axi_awaddr, `REG_CTRL) | addr_hit(s_axi_awaddr, `REG_IRQ_STAT)
    | addr_hit(s_axi_awaddr, `REG_IRQ_MASK) | addr_hit(s_axi_awaddr, `REG_STATUS)
    | addr_hit(s_axi_awaddr, `REG_COUNT);
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read data
  reg [31:0] rd_word;
  reg rd_known;
  always @* begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    if (addr_hit(s_axi_araddr, `REG_STATUS)) begin
      rd_word[`STAT_CPU_RST_BIT] = cpu_reset;
      rd_word[`STAT_SYS_RST_BIT] = sys_reset;
      rd_word[`STAT_OVF_BIT] = watchdog_overflow_flag;
      rd_word[`STAT_XTAL_BAD_BIT] = xtal_bad;
      rd_word[`STAT_WDT_OFF_BIT] = ~wdt_enable;
    end else if (addr_hit(s_axi_araddr, `REG_IRQ_STAT)) begin
      rd_word[`IRQ_WIDTH-1:0] = irq_stat;
    end else if (addr_hit(s_axi_araddr, `REG_IRQ_MASK)) begin
      rd_word[`IRQ_WIDTH-1:0] = irq_mask;
    end else if (addr_hit(s_axi_araddr, `REG_COUNT)) begin
      rd_word[15:0] = wdt_cnt;
    end else if (!addr_hit(s_axi_araddr, `REG_CTRL)) begin
      rd_known = 1'b0;
    end
  end

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'b00;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // hw_watchdog_reset_unit

// ===== inc/wdt_consts.vh
// Purpose: constants for the hardware watchdog and reset unit
// Assumes: mclk at 10 MHz, crystal_tick arrives as a level from the 32.768 kHz domain
// Notes: byte addresses of the AXI4-Lite register map
`ifndef WDT_CONSTS_VH
`define WDT_CONSTS_VH
`define MCLK_HZ 10000000
`define XTAL_HZ 32768
`define WDT_LIMIT_TICKS 49152
`define RESTART_TICKS 4100
`define EMU_REFRESH_CMD 8'h14
`define SLOW_TIMEOUT_CYC 1024
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_IRQ_STAT 8'h08
`define REG_IRQ_MASK 8'h0C
`define REG_COUNT 8'h10
`define CTRL_REFRESH_BIT 0
`define CTRL_CLR_OVF_BIT 1
`define STAT_OVF_BIT 2
`define STAT_CPU_RST_BIT 0
`define STAT_SYS_RST_BIT 1
`define STAT_XTAL_BAD_BIT 3
`define STAT_WDT_OFF_BIT 4
`define IRQ_OVF_BIT 0
`define IRQ_XTAL_BIT 1
`define IRQ_WIDTH 2
`endif

// ===== rtl/sync2.v
// Purpose: two flip-flop synchroniser for a bus of levels
// Assumes: inputs come from another clock domain or a pin
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module sync2 #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire mclk, // clock
  input wire rstn, // async reset, active low
  input wire ce, // clock enable
  input wire [W-1:0] d, // asynchronous levels
  output reg [W-1:0] q // synchronised levels
);
  reg [W-1:0] meta;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta <= INIT;
      q <= INIT;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // sync2

// ===== tb/wdt_checker_assertions.sv
// Purpose: port checks for hw_watchdog_reset_unit
// Assumes: ce only drops while the unit is idle
// Notes: bound at the foot
`timescale 1ns/1ns
module wdt_checker (
  input wire mclk, // clock
  input wire rstn, // reset
  input wire external_reset_pin_n, // pin
  input wire emu_reset_n, // emulator pin
  input wire power_fault_below_bias, // fault
  input wire power_fault_at_supply, // strap
  input wire cpu_reset, // cpu reset
  input wire sys_reset, // sys reset
  input wire config_clear, // clear
  input wire cpu_start, // start
  input wire s_axi_awvalid, // aw
  input wire s_axi_awready, // aw
  input wire s_axi_bvalid, // b
  input wire s_axi_bready, // b
  input wire [1:0] s_axi_bresp, // b
  input wire s_axi_rvalid, // r
  input wire s_axi_rready, // r
  input wire [31:0] s_axi_rdata // r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  pin_halt_a: assert property (!external_reset_pin_n [*4] |-> sys_reset && config_clear)
    else $error("pin low without halt");
  fault_clear_a: assert property ((power_fault_below_bias && !power_fault_at_supply) [*4] |-> config_clear)
    else $error("fault without clear");
  emu_reset_a: assert property (!emu_reset_n [*4] |-> sys_reset)
    else $error("emulator pin without reset");
  start_once_a: assert property (cpu_start |=> !cpu_start)
    else $error("start pulse too long");
  start_held_a: assert property (cpu_start |-> cpu_reset)
    else $error("start outside reset");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_ans_a: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write not answered");
  cover property (cpu_start);
  cover property (config_clear ##1 !config_clear);
  cover property (s_axi_bvalid && s_axi_bready);
endmodule // wdt_checker
bind hw_watchdog_reset_unit wdt_checker i_wdt_checker (.mclk(mclk), .rstn(rstn),
  .external_reset_pin_n(external_reset_pin_n), .emu_reset_n(emu_reset_n),
  .power_fault_below_bias(power_fault_below_bias), .power_fault_at_supply(power_fault_at_supply),
  .cpu_reset(cpu_reset), .sys_reset(sys_reset), .config_clear(config_clear), .cpu_start(cpu_start),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// ===== tb/xtal_src.sv
// Purpose: crystal oscillator stand-in
// Assumes: HALF mclk cycles per half period
// Notes: a stopped crystal stands still
`timescale 1ns/1ns
module xtal_src #(parameter HALF = 10) (
  input wire mclk, // clock
  input wire run, // oscillator running
  output reg tick // crystal level
);
  integer cnt = 0;
  initial tick = 1'b0;
  always @(posedge mclk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) tick <= ~tick;
    end
  end
endmodule // xtal_src

// ===== tb/hw_watchdog_reset_unit_test.sv
// Purpose: self-checking bench for hw_watchdog_reset_unit
// Assumes: short counts, 8 tick limit, 4 tick restart, tick period 20 mclk
// Notes: sleep_exit rests low so the count idles between tests
`timescale 1ns/1ns
module hw_watchdog_reset_unit_test;
  logic mclk = 0, rstn = 0, run = 1, pin_n = 1, emu_n = 1, low = 0, strap = 0, wake = 0, ecv = 0;
  logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic [7:0] ecmd = 8'h00, awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, seed = 32'hADFDEC38, rd;
  logic ce_on = 1;
  logic [3:0] ws = 4'hF;
  wire tick, cpu_reset, sys_reset, config_clear, cpu_start, irq, awr, wr_y, bv, arr, rv;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [3:0] ev = {config_clear, cpu_reset, sys_reset, cpu_start};
  integer err_total = 0, compares = 0, i, waited;
  always #50 mclk = ~mclk;
  xtal_src #(.HALF(10)) i_xtal_src (.mclk(mclk), .run(run), .tick(tick));
  hw_watchdog_reset_unit #(.WDT_LIMIT(8), .RESTART_TICKS(4), .SLOW_TIMEOUT(64)) i_hw_watchdog_reset_unit (
    .mclk(mclk), .rstn(rstn), .ce(ce_on), .crystal_tick(tick), .external_reset_pin_n(pin_n), .emu_reset_n(emu_n),
    .power_fault_below_bias(low), .power_fault_at_supply(strap), .sleep_exit(wake), .emu_cmd_valid(ecv),
    .emu_cmd(ecmd), .cpu_reset(cpu_reset), .sys_reset(sys_reset), .config_clear(config_clear),
    .cpu_start(cpu_start), .irq(irq), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_y), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry));
  function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [1:0] resp(input [7:0] a);
    resp = (a <= 8'h10 && a[1:0] == 2'b00) ? 2'b00 : 2'b10;
  endfunction
  task report_and_stop;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    compares = compares + 1;
    if (g !== e) begin
      err_total = err_total + 1;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task wait_ev(input integer s);
    for (waited = 0; waited < 3000 && ev[s] !== 1'b1; waited = waited + 1) @(posedge mclk);
    chk("event", 1, ev[s]);
    if (ev[s] !== 1'b1) report_and_stop;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    for (n = 0; n < 100 && !(bv && bry); n = n + 1) begin
      @(posedge mclk);
      if (awr) awv <= 0;
      if (wr_y) wv <= 0;
    end
    chk("bresp", resp(a), bv ? bresp : 2'bxx);
    if (bv !== 1'b1) report_and_stop;
    bry <= 0;
    @(posedge mclk);
  endtask
  task rdc(input [7:0] a, input [31:0] m, input [31:0] e);
    integer n;
    ara <= a;
    arv <= 1;
    rry <= 1;
    for (n = 0; n < 100 && !(rv && rry); n = n + 1) begin
      @(posedge mclk);
      if (arr) arv <= 0;
    end
    rd = rdata;
    chk("rresp", resp(a), rv ? rresp : 2'bxx);
    if (rv !== 1'b1) report_and_stop;
    if (resp(a) == 2'b00) chk("rdata", e, rd & m);
    rry <= 0;
    @(posedge mclk);
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rstn <= 1;
    @(posedge mclk);
    rdc(8'h04, 32'h1F, 32'h0);
    rdc(8'h00, 32'hFF, 32'h0);
    wr(8'h0C, 32'h3);
    rdc(8'h0C, 32'h3, 32'h3);
    ws <= 4'hE;
    wr(8'h0C, 32'h0);
    ws <= 4'hF;
    rdc(8'h0C, 32'h3, 32'h3);
    rdc(8'h20, 32'h0, 32'h0);
    wr(8'h24, 32'h0);
    $display("test map done");
    wake <= 1;
    for (i = 0; i < 12; i = i + 1) begin
      seed = nxt(seed);
      repeat (seed[5:0] + 20) @(posedge mclk);
      if (seed[6]) wr(8'h00, seed | 32'h1);
      else begin
        ecv <= 1;
        ecmd <= 8'h14;
        @(posedge mclk);
        ecv <= 0;
      end
    end
    // frozen clock enable: the count must not advance past the limit
    ce_on <= 0;
    repeat (300) @(posedge mclk);
    ce_on <= 1;
    wake <= 0;
    repeat (400) @(posedge mclk);
    rdc(8'h04, 32'h4, 32'h0);
    $display("test refresh done");
    wake <= 1;
    wait_ev(2);
    chk("limit", 1, waited >= 130 && waited <= 200);
    wait_ev(0);
    chk("restart", 1, waited >= 60 && waited <= 110);
    wake <= 0;
    rdc(8'h04, 32'h1F, 32'h4);
    rdc(8'h08, 32'h3, 32'h1);
    chk("irq", 1, irq);
    wr(8'h08, 32'h1);
    chk("irq", 0, irq);
    wr(8'h00, 32'h2);
    rdc(8'h04, 32'h4, 32'h0);
    $display("test overflow done");
    run <= 0;
    wait_ev(1);
    run <= 1;
    wait_ev(0);
    rdc(8'h04, 32'h4, 32'h4);
    rdc(8'h08, 32'h2, 32'h2);
    pin_n <= 0;
    wait_ev(3);
    repeat (3) @(posedge mclk);
    chk("sys", 1, sys_reset);
    pin_n <= 1;
    repeat (5) @(posedge mclk);
    rdc(8'h04, 32'h4, 32'h0);
    $display("test crystal and pin done");
    emu_n <= 0;
    wait_ev(1);
    repeat (3) @(posedge mclk);
    emu_n <= 1;
    low <= 1;
    wait_ev(3);
    repeat (3) @(posedge mclk);
    low <= 0;
    strap <= 1;
    repeat (5) @(posedge mclk);
    low <= 1;
    wake <= 1;
    repeat (400) @(posedge mclk);
    chk("clear", 0, config_clear);
    chk("cpu", 0, cpu_reset);
    rdc(8'h04, 32'h14, 32'h10);
    $display("test sources done");
    report_and_stop;
  end
endmodule // hw_watchdog_reset_unit_test
